// file: design/ccsw_pkg.sv
// Constants, types and helpers for the clock switch and fail-safe monitor.
// Assumes a 250 MHz reference clock and a single-cycle strobe register port.
// Behaviour
// - Stopped system clock forces fast RC, NMI
// - Sleep halts system clock and monitor
// - Software selects any of five sources
// - Primary submode fixed by configuration only
// - Switch-enable config bit 0 enables both
// - Disabled: next ignored, current shows default
// - Disabled: switch request reads zero always
// - Two key words unlock control writes
// - Equal current and next aborts, clears request
// - Valid switch clears PLL-ready and fail flags
// - Enable new oscillator, crystal waits start-up
// - PLL source waits for PLL-ready flag
// - Count ten new-clock cycles, then change
// - Completion clears request, copies next to current
// - Old source off unless kept enabled
// - Core never stalled during switching
// - Writing zero to key forces lock
package ccsw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int REF_PERIOD_NS = 4;
  localparam int FAIL_TIME_NS  = 2000;
  localparam int FAIL_CYCLES   = (FAIL_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int OST_TIME_NS   = 4096;
  localparam int OST_CYCLES    = (OST_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int SETTLE_CYCLES = 10;
  localparam int CNT_W         = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  KEY_ADDR    = 4'h0;
  localparam logic [3:0]  CTRL_ADDR   = 4'h4;
  localparam logic [3:0]  STAT_ADDR   = 4'h8;
  localparam logic [31:0] KEY_UNLOCK1 = 32'haa996655;
  localparam logic [31:0] KEY_UNLOCK2 = 32'h556699aa;
  localparam logic [31:0] KEY_LOCK    = 32'h00000000;

  localparam int CTRL_REQ_BIT    = 0;
  localparam int CTRL_SEC_EN_BIT = 1;
  localparam int CTRL_FAIL_BIT   = 3;
  localparam int CTRL_NEXT_LSB   = 8;
  localparam int CTRL_CUR_LSB    = 12;
  localparam int STAT_FRC_RDY    = 0;
  localparam int STAT_PRI_RDY    = 2;
  localparam int STAT_SEC_RDY    = 4;
  localparam int STAT_LOW_POWER_INTERNAL_RC_RDY   = 5;
  localparam int STAT_PLL_RDY    = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Sources, oscillators, submodes
  localparam logic [2:0] SRC_FRC  = 3'h0;
  localparam logic [2:0] SRC_PLL  = 3'h1;
  localparam logic [2:0] SRC_PRI  = 3'h2;
  localparam logic [2:0] SRC_SEC  = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;

  localparam int N_OSC    = 4;
  localparam int OSC_PRI  = 0;
  localparam int OSC_SEC  = 1;
  localparam int OSC_FRC  = 2;
  localparam int OSC_LOW_POWER_INTERNAL_RC = 3;

  localparam logic [1:0] SUB_EC = 2'h0;
  localparam logic [1:0] SUB_XT = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_CHECK    = 6'h02,
    ST_WAIT_OSC = 6'h04,
    ST_WAIT_PLL = 6'h08,
    ST_SETTLE   = 6'h10,
    ST_CHANGE   = 6'h20
  } ccsw_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillators that a source needs running
  function automatic logic [N_OSC-1:0] src_needs(input logic [2:0] src, input logic pll_pri);
    logic [N_OSC-1:0] m;
    m = '0;
    case (src)
      SRC_PLL:  m[pll_pri ? OSC_PRI : OSC_FRC] = 1'b1;
      SRC_PRI:  m[OSC_PRI] = 1'b1;
      SRC_SEC:  m[OSC_SEC] = 1'b1;
      SRC_LOW_POWER_INTERNAL_RC: m[OSC_LOW_POWER_INTERNAL_RC] = 1'b1;
      default:  m[OSC_FRC] = 1'b1;
    endcase
    return m;
  endfunction

  // Source runs from a crystal, so start-up timer applies
  function automatic logic src_crystal(input logic [2:0] src, input logic pll_pri, input logic [1:0] sub);
    logic pri;
    pri = (src == SRC_PRI) || ((src == SRC_PLL) && pll_pri);
    return (pri && (sub != SUB_EC)) || (src == SRC_SEC);
  endfunction

endpackage

// file: design/ccsw_sync.sv
// Two-flop synchroniser bank for asynchronous levels and toggles.
// Assumes each bit is independent; multi-bit words must be static.
`timescale 1ns/1ps
module ccsw_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// file: design/ccsw_clock_switch.sv
// Clock source switch controller with key lock and fail-safe clock monitor.
// Assumes oscillator ready, PLL lock, sleep and configuration arrive asynchronously,
// and that system and candidate clocks are reported as toggles.
`timescale 1ns/1ps
module ccsw_clock_switch
  import ccsw_pkg::*;
#(
  parameter int FAIL_CNT = ccsw_pkg::FAIL_CYCLES,
  parameter int OST_CNT  = ccsw_pkg::OST_CYCLES
) (
  // Clock and reset
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_rst_n,
  // Register port
  input  wire logic [ccsw_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [31:0]                 o_rdata,
  // Configuration
  input  wire logic                        i_switch_enable_config_bit,
  input  wire logic [2:0]                  i_default_source_config,
  input  wire logic [1:0]                  i_primary_submode_config,
  input  wire logic                        i_pll_input_primary,
  // Oscillator status and clock activity
  input  wire logic [ccsw_pkg::N_OSC-1:0]  i_osc_ready,
  input  wire logic [ccsw_pkg::N_OSC-1:0]  i_osc_keep,
  input  wire logic                        i_pll_lock,
  input  wire logic                        i_system_clock_toggle,
  input  wire logic                        i_candidate_clock_toggle,
  input  wire logic                        i_sleep,
  // Clock control
  output logic      [ccsw_pkg::N_OSC-1:0]  o_osc_enable,
  output logic      [2:0]                  o_system_clock_select,
  output logic      [2:0]                  o_candidate_select,
  output logic                             o_changeover,
  output logic      [1:0]                  o_primary_submode,
  output logic                             o_system_clock_run,
  output logic                             o_switch_busy,
  output logic                             o_nmi
);
  import ccsw_pkg::*;

  localparam int SYNC_W = 2 * N_OSC + 10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisation
  logic                rst_meta;
  logic                rst_n;
  logic [SYNC_W-1:0]   sync_in;
  logic [SYNC_W-1:0]   sync_out;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign sync_in = {i_osc_ready, i_osc_keep, i_pll_lock, i_system_clock_toggle, i_candidate_clock_toggle,
                    i_sleep, i_switch_enable_config_bit, i_default_source_config, i_primary_submode_config};

  ccsw_sync #(.WIDTH(SYNC_W)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_async   (sync_in),
    .o_sync    (sync_out)
  );

  // PLL input selection is a configuration pin too, so it gets its own two flops
  logic pll_in_s;

  ccsw_sync #(.WIDTH(1)) u_sync_pll (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (rst_n),
    .i_async   (i_pll_input_primary),
    .o_sync    (pll_in_s)
  );

  wire logic [N_OSC-1:0] osc_rdy  = sync_out[SYNC_W-1 -: N_OSC];
  wire logic [N_OSC-1:0] osc_keep = sync_out[N_OSC+9 -: N_OSC];
  wire logic             pll_lock = sync_out[9];
  wire logic             sys_tgl  = sync_out[8];
  wire logic             cand_tgl = sync_out[7];
  wire logic             sleep_s  = sync_out[6];
  wire logic             cfg_dis  = sync_out[5];
  wire logic [2:0]       cfg_src  = sync_out[4:2];
  wire logic [1:0]       cfg_sub  = sync_out[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture after release
  logic [1:0] cfg_wait;
  logic       cfg_taken;
  logic       sw_dis;
  logic       pll_pri;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wait  <= 2'h0;
      cfg_taken <= 1'b0;
      sw_dis    <= 1'b1;
      pll_pri   <= 1'b0;
      o_primary_submode <= SUB_EC;
    end else if (!cfg_taken) begin
      cfg_wait <= cfg_wait + 2'h1;
      if (cfg_wait == 2'h3) begin
        cfg_taken <= 1'b1;
        sw_dis    <= cfg_dis;
        pll_pri   <= pll_in_s;
        o_primary_submode <= cfg_sub;
      end
    end
  end

  wire logic sw_en = cfg_taken & ~sw_dis;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and key lock
  logic [1:0]     key_stage;
  logic [1:0]     next_key_stage;
  logic [2:0]     next_src;
  logic [2:0]     cur_src;
  logic [2:0]     tgt;
  logic           req;
  logic           sec_en;
  logic           fail_flag;
  logic           pll_flag;
  ccsw_state_type state;
  ccsw_state_type next_state;

  wire logic unlocked = (key_stage == 2'h2);
  wire logic wr_key   = i_wr & (i_addr == KEY_ADDR);
  wire logic wr_ctrl  = i_wr & (i_addr == CTRL_ADDR) & unlocked;

  always_comb begin
    next_key_stage = key_stage;
    if (wr_key) begin
      if (i_wdata == KEY_UNLOCK1)
        next_key_stage = 2'h1;
      else if ((i_wdata == KEY_UNLOCK2) && (key_stage == 2'h1))
        next_key_stage = 2'h2;
      else
        next_key_stage = 2'h0;
    end
  end

  wire logic [31:0] ctrl_word = {17'h0, cur_src, 1'b0, next_src, 4'h0, fail_flag, 1'b0, sec_en, req};
  wire logic [31:0] stat_word = {24'h0, pll_flag, 1'b0, osc_rdy[OSC_LOW_POWER_INTERNAL_RC], osc_rdy[OSC_SEC], 1'b0,
                                 osc_rdy[OSC_PRI], 1'b0, osc_rdy[OSC_FRC]};
  wire logic [31:0] rd_mux    = (i_addr == CTRL_ADDR) ? ctrl_word :
                                (i_addr == STAT_ADDR) ? stat_word : 32'h0;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_stage <= 2'h0;
      o_rdata   <= 32'h0;
    end else begin
      key_stage <= next_key_stage;
      o_rdata   <= i_rd ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe monitor
  logic             sys_d;
  logic [CNT_W-1:0] mon_cnt;
  logic             fail_evt;

  wire logic mon_active = sw_en & ~sleep_s;
  wire logic sys_edge   = sys_tgl ^ sys_d;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_d    <= 1'b0;
      mon_cnt  <= '0;
      fail_evt <= 1'b0;
    end else begin
      sys_d    <= sys_tgl;
      fail_evt <= mon_active & (mon_cnt == CNT_W'(FAIL_CNT - 1));
      if (!mon_active || sys_edge || fail_evt || (mon_cnt == CNT_W'(FAIL_CNT - 1)))
        mon_cnt <= '0;
      else
        mon_cnt <= mon_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch sequencer
  logic             cand_d;
  logic [CNT_W-1:0] ost_cnt;
  logic             ost_need;
  logic [3:0]       settle_cnt;

  wire logic [N_OSC-1:0] tgt_need  = src_needs(tgt, pll_pri);
  wire logic             tgt_ready = &(osc_rdy | ~tgt_need);
  wire logic             ost_done  = ~ost_need | (ost_cnt == CNT_W'(OST_CNT));
  wire logic             cand_edge = cand_tgl ^ cand_d;
  wire logic             redundant = (next_src == cur_src);
  wire logic             settled   = (settle_cnt == 4'(SETTLE_CYCLES));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:     if (req && sw_en) next_state = ST_CHECK;
      ST_CHECK:    next_state = redundant ? ST_IDLE : ST_WAIT_OSC;
      ST_WAIT_OSC: if (tgt_ready && ost_done) next_state = ST_WAIT_PLL;
      ST_WAIT_PLL: if (tgt != SRC_PLL || pll_flag) next_state = ST_SETTLE;
      ST_SETTLE:   if (settled) next_state = ST_CHANGE;
      ST_CHANGE:   next_state = ST_IDLE;
    endcase
    if (fail_evt)
      next_state = ST_IDLE;
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      tgt        <= SRC_FRC;
      cand_d     <= 1'b0;
      ost_cnt    <= '0;
      ost_need   <= 1'b0;
      settle_cnt <= 4'h0;
    end else begin
      state  <= next_state;
      cand_d <= cand_tgl;
      if (state == ST_CHECK) begin
        ost_need <= src_crystal(next_src, pll_pri, o_primary_submode) &
                    ~(&(o_osc_enable | ~src_needs(next_src, pll_pri)));
        ost_cnt  <= '0;
      end else if (state == ST_WAIT_OSC && !ost_done) begin
        ost_cnt <= ost_cnt + 1'b1;
      end
      if (state == ST_IDLE)
        tgt <= next_src;
      if (state != ST_SETTLE)
        settle_cnt <= 4'h0;
      else if (cand_edge && !settled)
        settle_cnt <= settle_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields and flags
  wire logic start_ok = (state == ST_CHECK) & ~redundant;
  wire logic req_done = ((state == ST_CHECK) & redundant) | (state == ST_CHANGE) | fail_evt;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      next_src  <= SRC_FRC;
      cur_src   <= SRC_FRC;
      req       <= 1'b0;
      sec_en    <= 1'b0;
      fail_flag <= 1'b0;
      pll_flag  <= 1'b0;
    end else begin
      if (!cfg_taken)
        cur_src <= cfg_src;
      else if (fail_evt)
        cur_src <= SRC_FRC;
      else if (state == ST_CHANGE)
        cur_src <= tgt;
      if (!cfg_taken)
        next_src <= cfg_src;
      else if (wr_ctrl)
        next_src <= i_wdata[CTRL_NEXT_LSB +: 3];
      if (!sw_en)
        req <= 1'b0;
      else if (wr_ctrl && i_wdata[CTRL_REQ_BIT])
        req <= 1'b1;
      else if (req_done)
        req <= 1'b0;
      if (wr_ctrl)
        sec_en <= i_wdata[CTRL_SEC_EN_BIT];
      if (fail_evt)
        fail_flag <= 1'b1;
      else if (start_ok || (wr_ctrl && !i_wdata[CTRL_FAIL_BIT]))
        fail_flag <= 1'b0;
      if (start_ok)
        pll_flag <= 1'b0;
      else if (pll_lock)
        pll_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the core clock keeps running throughout a switch
  wire logic [N_OSC-1:0] keep_mask = osc_keep | (sec_en ? N_OSC'(1 << OSC_SEC) : '0);
  wire logic [N_OSC-1:0] next_osc_enable = src_needs(cur_src, pll_pri) | keep_mask |
                                           ((state != ST_IDLE) ? tgt_need : '0);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_osc_enable          <= N_OSC'(1 << OSC_FRC);
      o_system_clock_select <= SRC_FRC;
      o_candidate_select    <= SRC_FRC;
      o_changeover          <= 1'b0;
      o_system_clock_run    <= 1'b1;
      o_switch_busy         <= 1'b0;
      o_nmi                 <= 1'b0;
    end else begin
      o_osc_enable          <= next_osc_enable;
      o_system_clock_select <= cur_src;
      o_candidate_select    <= tgt;
      o_changeover          <= (state == ST_CHANGE) & ~fail_evt;
      o_system_clock_run    <= ~sleep_s;
      o_switch_busy         <= (next_state != ST_IDLE);
      o_nmi                 <= fail_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_KEY_LOCK: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    wr_key && i_wdata == KEY_LOCK |=> !unlocked)
    else $error("key not locked after zero write");

  AST_UNLOCK_SEQ: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    !unlocked ##1 unlocked |-> $past(wr_key && i_wdata == KEY_UNLOCK2 && key_stage == 2'h1))
    else $error("unlock without key sequence");

  AST_LOCKED_IGNORE: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    i_wr && i_addr == CTRL_ADDR && !unlocked && cfg_taken |=> $stable(next_src) && $stable(sec_en))
    else $error("locked control write took effect");

  AST_REQ_ZERO_DIS: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    cfg_taken && sw_dis |=> !req && state == ST_IDLE)
    else $error("request active while switching disabled");

  AST_REDUNDANT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    state == ST_CHECK && redundant && !fail_evt |=> state == ST_IDLE && $stable(cur_src))
    else $error("redundant switch not aborted");

  AST_START_CLEARS: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    start_ok && !fail_evt |=> !fail_flag && !pll_flag)
    else $error("flags not cleared at switch start");

  AST_PLL_WAIT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    state == ST_WAIT_PLL && tgt == SRC_PLL && !pll_flag |=> state != ST_SETTLE)
    else $error("PLL source left wait without lock");

  AST_SETTLE_COUNT: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    state == ST_SETTLE && !fail_evt ##1 state == ST_CHANGE |-> $past(settle_cnt) == 4'(SETTLE_CYCLES))
    else $error("changeover before ten new-clock cycles");

  AST_CHANGE_COPY: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    state == ST_CHANGE && !fail_evt && !wr_ctrl |=> cur_src == $past(tgt) && !req ##1 o_changeover == 1'b0)
    else $error("changeover did not copy source or clear request");

  AST_FAIL_FRC: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    fail_evt |=> cur_src == SRC_FRC && fail_flag && o_nmi ##1 o_system_clock_select == SRC_FRC)
    else $error("clock failure not handled");

  AST_SLEEP_NOMON: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    sleep_s ##1 sleep_s |-> !fail_evt)
    else $error("monitor fired during sleep");

endmodule

// file: tb/ccsw_clock_switch_bench.sv
// Self-checking bench for the clock source switch controller and fail-safe monitor.
// Assumes ccsw_pkg and the design modules are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module ccsw_clock_switch_bench;
  import ccsw_pkg::*;
  localparam int FCNT = 20;
  localparam int OCNT = 8;
  localparam int CDIV = 4;
  localparam int TMAX = 20000;
  typedef struct {logic [31:0] val; logic [31:0] mask;} ccsw_note_type;

  ////////////////////////////////////////////////////////////////////////////
  logic              i_ref_clk                  = 1'b0;
  logic              i_rst_n                    = 1'b0;
  logic [ADDR_W-1:0] i_addr                     = '0;
  logic [31:0]       i_wdata                    = '0;
  logic              i_wr                       = 1'b0;
  logic              i_rd                       = 1'b0;
  logic              i_switch_enable_config_bit = 1'b0;
  logic [2:0]        i_default_source_config    = SRC_FRC;
  logic [1:0]        i_primary_submode_config   = SUB_XT;
  logic              i_pll_input_primary        = 1'b0;
  logic [N_OSC-1:0]  i_osc_ready                = 4'h4;
  logic [N_OSC-1:0]  i_osc_keep                 = 4'h0;
  logic              i_pll_lock                 = 1'b1;
  logic              i_system_clock_toggle      = 1'b0;
  logic              i_candidate_clock_toggle   = 1'b0;
  logic              i_sleep                    = 1'b0;
  logic [31:0]       o_rdata;
  logic [N_OSC-1:0]  o_osc_enable;
  logic [2:0]        o_system_clock_select;
  logic [2:0]        o_candidate_select;
  logic              o_switch_busy;
  logic              o_changeover;
  logic [1:0]        o_primary_submode;
  logic              o_system_clock_run;
  logic              o_nmi;
  logic              sys_alive                  = 1'b1;
  logic [1:0]        div                        = 2'h0;
  logic              rd_seen                    = 1'b0;
  logic              co_seen                    = 1'b0;
  logic [2:0]        cur                        = SRC_FRC;
  logic [2:0]        codes [5]                  = '{SRC_FRC, SRC_PLL, SRC_PRI, SRC_SEC, SRC_LOW_POWER_INTERNAL_RC};
  ccsw_note_type     exp_q [$];
  logic [2:0]        sel_q [$];
  int                err_count                  = 0;
  int                checks                     = 0;
  int                co_cnt                     = 0;
  int                nmi_cnt                    = 0;
  int                cyc                        = 0;

  ccsw_clock_switch #(.FAIL_CNT(FCNT), .OST_CNT(OCNT)) i_ccsw_clock_switch (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_switch_enable_config_bit(i_switch_enable_config_bit),
    .i_default_source_config(i_default_source_config), .i_primary_submode_config(i_primary_submode_config),
    .i_pll_input_primary(i_pll_input_primary), .i_osc_ready(i_osc_ready), .i_osc_keep(i_osc_keep),
    .i_pll_lock(i_pll_lock), .i_system_clock_toggle(i_system_clock_toggle),
    .i_candidate_clock_toggle(i_candidate_clock_toggle), .i_sleep(i_sleep), .o_osc_enable(o_osc_enable),
    .o_system_clock_select(o_system_clock_select), .o_candidate_select(o_candidate_select),
    .o_changeover(o_changeover), .o_primary_submode(o_primary_submode),
    .o_system_clock_run(o_system_clock_run), .o_switch_busy(o_switch_busy),
    .o_nmi(o_nmi));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, oscillator and clock-activity models
  always #2 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    div <= div + 2'd1;
    if (sys_alive) i_system_clock_toggle <= ~i_system_clock_toggle;
    if (div == 2'd3) i_candidate_clock_toggle <= ~i_candidate_clock_toggle;
    i_osc_ready <= o_osc_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking and result monitor
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    ccsw_note_type note;
    if (rd_seen) begin
      note = exp_q.pop_front();
      check("rdata", note.val, o_rdata & note.mask);
    end
    if (co_seen) check("select", {29'h0, sel_q.pop_front()}, {29'h0, o_system_clock_select});
    rd_seen = i_rd;
    co_seen = o_changeover;
    if (o_changeover) co_cnt++;
    if (o_nmi) nmi_cnt++;
    cyc++;
    if (cyc == TMAX) begin
      err_count++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port master
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_rd    <= 1'b0;
    i_addr  <= a;
    i_wdata <= d;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_wr   <= 1'b0;
    i_addr <= a;
    exp_q.push_back('{v & m, m});
  endtask

  task automatic idle();
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  task automatic unlock();
    wr(KEY_ADDR, KEY_UNLOCK1);
    wr(KEY_ADDR, KEY_UNLOCK2);
  endtask

  task automatic do_reset(input logic en, input logic [2:0] src);
    @(posedge i_ref_clk);
    i_rst_n                    <= 1'b0;
    i_switch_enable_config_bit <= en;
    i_default_source_config    <= src;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    cur = src;
    repeat (12) @(posedge i_ref_clk);
  endtask

  function automatic logic [3:0] osc_of(input logic [2:0] s);
    case (s)
      SRC_PRI:  return 4'h1;
      SRC_SEC:  return 4'h2;
      SRC_LOW_POWER_INTERNAL_RC: return 4'h8;
      default:  return 4'h4;
    endcase
  endfunction

  task automatic switch_to(input logic [2:0] s, input int min_cyc);
    int n;
    int c0;
    n = 0;
    c0 = co_cnt;
    unlock();
    wr(CTRL_ADDR, 32'(s) << CTRL_NEXT_LSB);
    wr(CTRL_ADDR, (32'(s) << CTRL_NEXT_LSB) | 32'h1);
    wr(KEY_ADDR, KEY_LOCK);
    idle();
    if (s == cur) begin
      repeat (6) @(posedge i_ref_clk);
      check("abort", 32'(c0), 32'(co_cnt));
    end else begin
      sel_q.push_back(s);
      @(posedge i_ref_clk);
      check("busy_on", 32'h1, {31'h0, o_switch_busy});
      while (co_cnt == c0 && n < 3000) begin
        @(posedge i_ref_clk);
        n++;
      end
      check("settle", 32'h1, 32'(n >= min_cyc && n < 3000));
      repeat (4) @(posedge i_ref_clk);
      check("osc_en", {28'h0, osc_of(s)}, {28'h0, o_osc_enable});
      check("cand", {29'h0, s}, {29'h0, o_candidate_select});
      check("busy_off", 32'h0, {31'h0, o_switch_busy});
      cur = s;
    end
    rd(CTRL_ADDR, 32'(cur) << CTRL_CUR_LSB, 32'h7009);
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int c0;
    int n;
    void'($urandom(32'h74f2ca0f));
    do_reset(1'b0, SRC_FRC);
    check("submode", {30'h0, SUB_XT}, {30'h0, o_primary_submode});
    rd(4'hc, 32'h0, 32'hffffffff);
    rd(KEY_ADDR, 32'h0, 32'hffffffff);
    wr(CTRL_ADDR, (32'(SRC_PRI) << CTRL_NEXT_LSB) | 32'h1);
    unlock();
    wr(KEY_ADDR, KEY_LOCK);
    wr(CTRL_ADDR, (32'(SRC_SEC) << CTRL_NEXT_LSB) | 32'h1);
    idle();
    repeat (4) @(posedge i_ref_clk);
    rd(CTRL_ADDR, 32'h0, 32'h0701);
    idle();
    $display("test lock done");
    switch_to(SRC_FRC, 0);
    switch_to(SRC_PRI, OCNT + 9 * CDIV);
    $display("test switch done");
    c0 = nmi_cnt;
    sys_alive <= 1'b0;
    for (n = 0; n < 100 && nmi_cnt == c0; n++) @(posedge i_ref_clk);
    sys_alive <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    check("nmi", 32'h1, 32'(nmi_cnt > c0 && n >= FCNT));
    check("fail_sel", {29'h0, SRC_FRC}, {29'h0, o_system_clock_select});
    rd(CTRL_ADDR, 32'h8, 32'h7009);
    idle();
    cur = SRC_FRC;
    switch_to(SRC_SEC, 9 * CDIV);
    $display("test monitor done");
    i_pll_lock <= 1'b0;
    fork
      begin
        repeat (150) @(posedge i_ref_clk);
        i_pll_lock <= 1'b1;
      end
    join_none
    switch_to(SRC_PLL, 140);
    switch_to(SRC_LOW_POWER_INTERNAL_RC, 9 * CDIV);
    for (n = 0; n < 4; n++) switch_to(codes[$urandom_range(4, 0)], 9 * CDIV);
    $display("test sources done");
    c0 = nmi_cnt;
    i_sleep <= 1'b1;
    sys_alive <= 1'b0;
    repeat (100) @(posedge i_ref_clk);
    check("sleep_nmi", 32'(c0), 32'(nmi_cnt));
    check("sleep_run", 32'h0, {31'h0, o_system_clock_run});
    i_sleep <= 1'b0;
    sys_alive <= 1'b1;
    repeat (10) @(posedge i_ref_clk);
    check("wake_run", 32'h1, {31'h0, o_system_clock_run});
    $display("test sleep done");
    do_reset(1'b1, SRC_LOW_POWER_INTERNAL_RC);
    c0 = co_cnt + nmi_cnt;
    unlock();
    wr(CTRL_ADDR, (32'(SRC_FRC) << CTRL_NEXT_LSB) | 32'h1);
    idle();
    sys_alive <= 1'b0;
    repeat (100) @(posedge i_ref_clk);
    sys_alive <= 1'b1;
    check("disabled", 32'(c0), 32'(co_cnt + nmi_cnt));
    check("dis_sel", {29'h0, SRC_LOW_POWER_INTERNAL_RC}, {29'h0, o_system_clock_select});
    rd(CTRL_ADDR, 32'(SRC_LOW_POWER_INTERNAL_RC) << CTRL_CUR_LSB, 32'h7001);
    idle();
    repeat (3) @(posedge i_ref_clk);
    $display("test disabled done");
    report_and_stop();
  end
endmodule
